// *** pkg/bcd_pkg.sv ***
// shared constants and types for the three-phase commutation and pwm drive
package bcd_pkg;

  // ------------------------------------------------------------
  // timing and widths
  // ------------------------------------------------------------
  localparam int          CLK_HZ         = 40000000;
  localparam int          LEVEL_W        = 8;
  localparam int          PWM_HZ_DEF     = 19000;
  localparam int          PWM_STEPS      = 256;
  localparam int          PWM_DIV_CYC    = CLK_HZ / (PWM_HZ_DEF * PWM_STEPS);
  localparam logic [7:0]  PWM_DIV_RST    = 8'h00;
  localparam logic [7:0]  RAMP_RST       = 8'h00;

  // ------------------------------------------------------------
  // duty thresholds as codes on a 0..5 v scale
  // ------------------------------------------------------------
  localparam real         CTL_LOW_V      = 1.3;
  localparam real         CTL_HIGH_V     = 3.1;
  localparam logic [7:0]  CTL_LOW_CODE   = 8'h42;
  localparam logic [7:0]  CTL_HIGH_CODE  = 8'h9e;

  // ------------------------------------------------------------
  // phase drive encoding
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_OFF,
    PH_LOW,
    PH_HIGH
  } bcd_phase_t;

endpackage : bcd_pkg

// *** pkg/bcd_duty_if.sv ***
// duty comparator link between the drive top and the pwm comparator
`timescale 1ns/1ps
interface bcd_duty_if;
  import bcd_pkg::*;
  logic [LEVEL_W-1:0] ctl_code;
  logic [LEVEL_W-1:0] min_code;
  logic               ctl_float;
  logic               pwm_on;
  logic               pwm_tick;
  modport top (output ctl_code, output min_code, output ctl_float,
               input pwm_on, input pwm_tick);
  modport cmp (input ctl_code, input min_code, input ctl_float,
               output pwm_on, output pwm_tick);
endinterface : bcd_duty_if

// *** src/bcd_pwm_cmp.sv ***
// pwm ramp counter and duty comparator
`timescale 1ns/1ps
module bcd_pwm_cmp
  import bcd_pkg::*;
#(
  parameter int DIV_CYC = PWM_DIV_CYC
) (
  input  wire logic   mclk_in,
  input  wire logic   srst_in,
  bcd_duty_if.cmp     duty
);

  // ------------------------------------------------------------
  // ramp: free-running counter with enable from a divider
  // ------------------------------------------------------------
  logic [7:0] div_r, div_nxt;
  logic [7:0] ramp_r, ramp_nxt;
  logic       on_r, on_nxt;
  logic       tick_r, tick_nxt;
  logic [7:0] ctl_eff;

  // maps the analog window onto the full ramp span
  function automatic logic [7:0] scale_ctl(input logic [7:0] c);
    logic [15:0] num;
    num = 16'h0000;
    if (c <= CTL_LOW_CODE) return 8'h00;
    if (c >= CTL_HIGH_CODE) return 8'hff;
    num = 16'((c - CTL_LOW_CODE) * 16'h00ff);
    return 8'(num / 16'(CTL_HIGH_CODE - CTL_LOW_CODE));
  endfunction : scale_ctl

  always_comb begin
    div_nxt  = div_r + 8'h01;
    ramp_nxt = ramp_r;
    tick_nxt = 1'b0;
    if (div_r >= 8'(DIV_CYC - 1)) begin
      div_nxt  = 8'h00;
      ramp_nxt = ramp_r + 8'h01; // RL15
      tick_nxt = 1'b1;
    end
    ctl_eff = duty.ctl_float ? 8'hff : scale_ctl(duty.ctl_code); // RL7
    // floor is a raw ramp compare, so it never goes below the minimum level
    on_nxt = (ctl_eff == 8'hff) || (ramp_r < ctl_eff) || (ramp_r < duty.min_code); // RL4 RL5 RL6
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      div_r  <= PWM_DIV_RST;
      ramp_r <= RAMP_RST;
      on_r   <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      ramp_r <= ramp_nxt;
      on_r   <= on_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign duty.pwm_on   = on_r;
  assign duty.pwm_tick = tick_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  full_duty_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL7
    duty.ctl_float |=> on_r) else $error("floating control not full duty");
  zero_duty_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL5
    (duty.ctl_code <= CTL_LOW_CODE && duty.min_code == 8'h00 && !duty.ctl_float)
    |=> !on_r) else $error("duty not zero below low level");
  duty_floor_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL6
    (ramp_r < duty.min_code) |=> on_r) else $error("minimum duty floor violated");
  ramp_step_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL15
    tick_nxt |=> ramp_r == 8'($past(ramp_r) + 8'h01)) else $error("ramp did not step");
  partial_c: cover property (@(posedge mclk_in) on_r ##1 !on_r);

endmodule : bcd_pwm_cmp

// *** src/bcd_drive_top.sv ***
// three-phase brushless drive: hall decode, pwm, rectification, protections
//
// How it works
// [RL1] hall level high when plus exceeds minus
// [RL2] six-step table; reverse decodes inverted hall
// [RL3] low side on during high-side pwm off
// [RL4] duty from control level versus ramp
// [RL5] zero below 1.3v, full above 3.1v
// [RL6] minimum duty level sets a duty floor
// [RL7] floating control input gives full duty
// [RL8] gate supply margin low cuts high side
// [RL9] current limit reached cuts high side
// [RL10] stop mode turns hall bias off
// [RL11] tacho output open drain, pulls low only
// [RL12] equal hall levels turn all switches off
// [RL13] stop when start input high, all off
// [RL14] tacho output follows hall phase a
// [RL15] ramp is counter compared with codes
`timescale 1ns/1ps
module bcd_drive_top
  import bcd_pkg::*;
#(
  parameter int DIV_CYC = PWM_DIV_CYC
) (
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  input  wire logic [2:0]         hall_pos_in,
  input  wire logic [2:0]         hall_neg_in,
  input  wire logic               dir_rev_in,
  input  wire logic               stop_in,
  input  wire logic [LEVEL_W-1:0] speed_control_level_in,
  input  wire logic               speed_control_float_in,
  input  wire logic [LEVEL_W-1:0] min_duty_level_in,
  input  wire logic               gate_margin_low_in,
  input  wire logic               current_sense_threshold_in,
  output logic [2:0]              high_side_out,
  output logic [2:0]              low_side_out,
  output logic                    sensor_bias_switch_out,
  output logic                    tacho_pulse_out,
  output logic                    tacho_pulse_oe_out
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int SW = 11 + 2 * LEVEL_W;
  logic [SW-1:0] s1_r, s2_r;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {hall_pos_in, hall_neg_in, dir_rev_in, stop_in, speed_control_float_in,
               gate_margin_low_in, current_sense_threshold_in, speed_control_level_in,
               min_duty_level_in};
      s2_r <= s1_r;
    end
  end

  logic [2:0]         hp, hn;
  logic               rev, stop, flt, gate_low, ilim;
  logic [LEVEL_W-1:0]   ctl_raw, min_raw, ctl_s, min_s;
  logic [2*LEVEL_W-1:0] lvl_prev_r, lvl_prev_nxt, lvl_r, lvl_nxt;
  assign {hp, hn, rev, stop, flt, gate_low, ilim, ctl_raw, min_raw} = s2_r;

  // level codes cross bit by bit; a code is taken only once two synced
  // samples agree, so a skewed word never reaches the comparator
  always_comb begin
    lvl_prev_nxt = {ctl_raw, min_raw};
    lvl_nxt      = lvl_r;
    if ({ctl_raw, min_raw} == lvl_prev_r) begin
      lvl_nxt = lvl_prev_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      lvl_prev_r <= '0;
      lvl_r      <= '0;
    end else begin
      lvl_prev_r <= lvl_prev_nxt;
      lvl_r      <= lvl_nxt;
    end
  end

  assign {ctl_s, min_s} = lvl_r;

  // ------------------------------------------------------------
  // pwm comparator
  // ------------------------------------------------------------
  bcd_duty_if duty ();
  assign duty.ctl_code  = ctl_s;
  assign duty.min_code  = min_s;
  assign duty.ctl_float = flt;

  bcd_pwm_cmp #(.DIV_CYC(DIV_CYC)) u_cmp (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .duty    (duty)
  );

  // ------------------------------------------------------------
  // commutation decode
  // ------------------------------------------------------------
  function automatic logic [5:0] decode(input logic [2:0] h);
    // returns {ph_a, ph_b, ph_c} as 2-bit phase codes
    case (h)
      3'b101:  return {PH_LOW,  PH_HIGH, PH_OFF};
      3'b100:  return {PH_LOW,  PH_OFF,  PH_HIGH};
      3'b110:  return {PH_OFF,  PH_LOW,  PH_HIGH};
      3'b010:  return {PH_HIGH, PH_LOW,  PH_OFF};
      3'b011:  return {PH_HIGH, PH_OFF,  PH_LOW};
      3'b001:  return {PH_OFF,  PH_HIGH, PH_LOW};
      default: return {PH_OFF,  PH_OFF,  PH_OFF}; // RL12
    endcase
  endfunction : decode

  logic [2:0] hall;
  logic [5:0] step;
  logic [2:0] hs_nxt, ls_nxt, hs_r, ls_r;
  logic       hb_nxt, hb_r, tacho_oe_nxt, tacho_oe_r;
  logic       hs_ok;

  always_comb begin
    hall   = {hp[2] > hn[2], hp[1] > hn[1], hp[0] > hn[0]}; // RL1
    step   = decode(rev ? ~hall : hall); // RL2
    // margin and current limit only gate the high side, low side keeps braking
    hs_ok  = duty.pwm_on && !gate_low && !ilim; // RL8 RL9
    hs_nxt = 3'b000;
    ls_nxt = 3'b000;
    for (int i = 0; i < 3; i++) begin
      case (bcd_phase_t'(step[5-2*i -: 2]))
        PH_HIGH: begin
          hs_nxt[2-i] = hs_ok;
          ls_nxt[2-i] = !hs_ok; // RL3
        end
        PH_LOW:  ls_nxt[2-i] = 1'b1;
        default: ;
      endcase
    end
    if (stop) begin
      hs_nxt = 3'b000; // RL13
      ls_nxt = 3'b000;
    end
    hb_nxt       = !stop; // RL10
    tacho_oe_nxt = !hall[2]; // RL11 RL14
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hs_r       <= 3'b000;
      ls_r       <= 3'b000;
      hb_r       <= 1'b0;
      tacho_oe_r <= 1'b0;
    end else begin
      hs_r       <= hs_nxt;
      ls_r       <= ls_nxt;
      hb_r       <= hb_nxt;
      tacho_oe_r <= tacho_oe_nxt;
    end
  end

  assign high_side_out          = hs_r;
  assign low_side_out           = ls_r;
  assign sensor_bias_switch_out = hb_r;
  // open drain: data is a constant low, only the enable moves
  always_comb tacho_pulse_out = 1'b0; // RL11
  assign tacho_pulse_oe_out     = tacho_oe_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  no_shoot_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL3
    (high_side_out & low_side_out) == 3'b000) else $error("shoot-through on a phase");
  stop_off_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL13
    stop |=> (high_side_out == 3'b000 && low_side_out == 3'b000 && !sensor_bias_switch_out))
    else $error("outputs active in stop mode");
  bias_on_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL10
    !stop |=> sensor_bias_switch_out) else $error("hall bias off while running");
  hall_equal_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL12
    (hall == 3'b000 || hall == 3'b111) |=> (high_side_out == 3'b000 && low_side_out == 3'b000))
    else $error("switches on with equal hall levels");
  hs_cut_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL8 RL9
    (gate_low || ilim) |=> high_side_out == 3'b000) else $error("high side not cut");
  tacho_follow_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL14
    !$past(srst_in) |-> tacho_pulse_oe_out == !$past(hall[2]) && tacho_pulse_out == 1'b0)
    else $error("tacho does not follow hall a");
  rect_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL3
    (!stop && hall == 3'b010 && !rev && !hs_ok) |=> low_side_out[2] && !high_side_out[2])
    else $error("no rectification during pwm off");
  fwd_step_a: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
    (!stop && hall == 3'b101 && !rev)
    |=> low_side_out[2] && !high_side_out[2] && !low_side_out[0] && !high_side_out[0])
    else $error("wrong forward decode");
  drive_c: cover property (@(posedge mclk_in) |high_side_out);
  rect_c:  cover property (@(posedge mclk_in) |high_side_out ##1 !(|high_side_out) && |low_side_out);
  rev_c:   cover property (@(posedge mclk_in) rev && |high_side_out);
  ramp_c:  cover property (@(posedge mclk_in) duty.pwm_tick && |high_side_out);

endmodule : bcd_drive_top

// *** test/bcd_motor_model.sv ***
// motor model: rotor position to differential hall pairs
`timescale 1ns/1ps
module bcd_motor_model (
  input  wire logic       mclk_in,
  input  wire logic       step_in,
  input  wire logic       spin_rev_in,
  input  wire logic       equal_in,
  output logic      [2:0] hall_pos_out,
  output logic      [2:0] hall_neg_out
);
  logic [2:0] seq [6];
  logic [2:0] mix_r;
  logic [2:0] lvl;
  int         pos_r;
  initial begin
    seq   = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    pos_r = 0;
    mix_r = 3'h0;
  end
  // low phases show equal wires; common mode wanders every cycle
  always @(posedge mclk_in) begin
    mix_r <= #2 3'($urandom);
    if (step_in)
      pos_r <= #2 spin_rev_in ? (pos_r + 5) % 6 : (pos_r + 1) % 6;
  end
  // stuck sensors all read alike
  assign lvl          = equal_in ? {3{seq[pos_r][2]}} : seq[pos_r];
  assign hall_pos_out = lvl | mix_r;
  assign hall_neg_out = ~lvl & mix_r;
endmodule : bcd_motor_model

// *** test/tb_top.sv ***
// self-checking bench for the three-phase drive
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import bcd_pkg::*;
  localparam int DIV = 2;
  localparam int PER = 256 * DIV;
  logic         mclk_in = 1'b0;
  logic         srst_in = 1'b1;
  logic [2:0]   hp, hn, h, hpm, hpx, hi, lo;
  logic         rev = 1'b0, stop = 1'b0, flt = 1'b0, gate = 1'b0, ilim = 1'b0;
  logic         step = 1'b0, spin = 1'b0, equal = 1'b0, on, bias, tacho, toe;
  logic [7:0]   ctl = 8'h00, min = 8'h00;
  int           fails = 0, checked = 0, cyc = 0, n, prev, sel;

  bcd_motor_model motor (.mclk_in(mclk_in), .step_in(step), .spin_rev_in(spin),
    .equal_in(equal), .hall_pos_out(hp), .hall_neg_out(hn));
  bcd_drive_top #(.DIV_CYC(DIV)) dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .hall_pos_in(hp), .hall_neg_in(hn), .dir_rev_in(rev), .stop_in(stop),
    .speed_control_level_in(ctl), .speed_control_float_in(flt), .min_duty_level_in(min),
    .gate_margin_low_in(gate), .current_sense_threshold_in(ilim), .high_side_out(hi),
    .low_side_out(lo), .sensor_bias_switch_out(bias), .tacho_pulse_out(tacho),
    .tacho_pulse_oe_out(toe));

  initial forever #12.5 mclk_in = ~mclk_in;

  // hang guard: whole run is about 6000 cycles
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic logic [5:0] exp_sw(logic [2:0] hl, logic r, logic st, logic o);
    logic [2:0] d, up, dn;
    d = r ? ~hl : hl;
    case (d)
      3'h5: begin up = 3'h2; dn = 3'h4; end
      3'h4: begin up = 3'h1; dn = 3'h4; end
      3'h6: begin up = 3'h1; dn = 3'h2; end
      3'h2: begin up = 3'h4; dn = 3'h2; end
      3'h3: begin up = 3'h4; dn = 3'h1; end
      3'h1: begin up = 3'h2; dn = 3'h1; end
      default: begin up = 3'h0; dn = 3'h0; end
    endcase
    if (st) begin
      up = 3'h0;
      dn = 3'h0;
    end
    return {o ? up : 3'h0, dn | (o ? 3'h0 : up)};
  endfunction : exp_sw

  // counts high-side on cycles of the driven phase over one ramp period
  task automatic duty_cnt(input logic [7:0] c, input logic [7:0] m);
    ctl = c;
    min = m;
    repeat (8) @(posedge mclk_in);
    #2 n = 0;
    repeat (PER) begin
      @(posedge mclk_in);
      #2 n += int'(|(hi & hpm));
      `CHK((|(hi & hpm)) ^ (|(lo & hpm)), 1'b1)
    end
  endtask : duty_cnt

  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    void'($urandom(32'ha84a));
    repeat (5) @(posedge mclk_in);
    #2 `CHK({hi, lo, bias, toe}, 8'h00)
    srst_in = 1'b0;
    repeat (150) begin
      sel   = $urandom % 3;
      step  = 1'b1;
      spin  = 1'($urandom);
      equal = ($urandom % 8) == 0;
      rev   = 1'($urandom);
      stop  = ($urandom % 4) == 0;
      gate  = ($urandom % 4) == 0;
      ilim  = ($urandom % 4) == 0;
      flt   = sel == 2;
      ctl   = 8'($urandom % 'h42) + (sel == 1 ? CTL_HIGH_CODE : 8'h00);
      @(posedge mclk_in);
      #2 step = 1'b0;
      repeat (6) @(posedge mclk_in);
      #2 h = hp & ~hn;
      on = sel != 0 && !gate && !ilim;
      `CHK({hi, lo}, exp_sw(h, rev, stop, on))
      `CHK(bias, ~stop)
      `CHK({tacho, toe}, {1'b0, ~h[2]})
    end
    {stop, gate, ilim, flt, rev, equal} = 6'h00;
    repeat (8) @(posedge mclk_in);
    #2 h = hp & ~hn;
    {hpm, hpx} = exp_sw(h, 1'b0, 1'b0, 1'b1);
    for (int m = 'h40; m < 'h100; m += 'h40) begin
      duty_cnt(8'h00, 8'(m));
      `CHK(n, m * DIV)
    end
    prev = -1;
    for (int c = 'h42; c < 'h9e; c += 'h14) begin
      duty_cnt(8'(c), 8'h00);
      `CHK(n > prev, 1'b1)
      prev = n;
    end
    srst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #2 `CHK({hi, lo, bias, toe}, 8'h00)
    srst_in = 1'b0;
    duty_cnt(CTL_HIGH_CODE, 8'h00);
    `CHK(n, PER)
    stop_test();
  end
endmodule : tb_top
